/* src/scr_defs.svh */
// offsets, field positions, reset values and timing counts of the serializer control bank
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_ADDR_CFG_ONE   8'h00
`define SCR_ADDR_BUS_ID    8'h01
`define SCR_ADDR_EMPH      8'h02

`define SCR_CFG_REG_BIT    0
`define SCR_CFG_SLEEP_BIT  1
`define SCR_CFG_MODE_LSB   2
`define SCR_CFG_MODE_MSB   3
`define SCR_CFG_EDGE_BIT   4
`define SCR_CFG_SWING_BIT  5
`define SCR_ID_SRC_BIT     7
`define SCR_ID_ADDR_MSB    6
`define SCR_EMPH_DIS_BIT   4
`define SCR_EMPH_LVL_LSB   5
`define SCR_EMPH_LVL_MSB   7

`define SCR_CFG_ONE_RST    8'h00
`define SCR_BUS_ID_RST     8'h68
`define SCR_EMPH_RST       8'h00
`define SCR_CFG_ONE_MASK   8'h3F
`define SCR_EMPH_MASK      8'hF0

`define SCR_MODE_FILT_OFF  2'h0
`define SCR_MODE_FILT_ON   2'h1
`define SCR_MODE_GEN2      2'h2
`define SCR_MODE_GEN1      2'h3
`define SCR_EMPH_EXTERNAL  3'h0

`define SCR_VALID_ADDR_0   7'h69
`define SCR_VALID_ADDR_1   7'h6A
`define SCR_VALID_ADDR_2   7'h6B
`define SCR_VALID_ADDR_3   7'h6E

`define SCR_CLK_HZ         25000000
`define SCR_POWERUP_MS     10
`define SCR_POWERUP_CYC    ((`SCR_CLK_HZ / 1000) * `SCR_POWERUP_MS)

`endif

/* src/scr_pkg.sv */
// types shared by the serializer control bank
package scr_pkg;

  typedef logic [7:0] scr_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_RXB,
    ST_WACK,
    ST_TXB,
    ST_RACK
  } scr_bus_state_e;

endpackage

/* src/scr_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module scr_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin
    $error("scr_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        meta_r[i]   <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else begin
        meta_r[i]   <= async_in[i];
        sync_out[i] <= meta_r[i];
      end
    end
  end

endmodule

/* src/scr_regs.sv */
// serializer control register bank behind a two-wire serial control bus
`timescale 1ns/1ps
`include "scr_defs.svh"

module scr_regs #(
  parameter int POWERUP_CYCLES = `SCR_POWERUP_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // serial control bus, open drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // device pins
  input  wire logic       power_down_n,
  input  wire logic [1:0] strap_mode,
  input  wire logic       strap_latch_edge_select,
  input  wire logic       strap_output_swing_select,
  input  wire logic [6:0] pin_bus_address,
  // effective configuration
  output logic [1:0]      compat_mode,
  output logic            ctl_filter_en,
  output logic            backcompat_gen2,
  output logic            backcompat_gen1,
  output logic            sleep_mode,
  output logic            latch_edge_select,
  output logic            output_swing_select,
  output logic [2:0]      emphasis_level,
  output logic            emphasis_disable,
  output logic [6:0]      bus_address_field,
  output logic            bus_ready
);

  localparam int CW = $clog2(POWERUP_CYCLES + 1);

  if (POWERUP_CYCLES < 1) begin
    $error("scr_regs: POWERUP_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [13:0] pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        pdn_s;
  logic [1:0]  strap_mode_s;
  logic        strap_edge_s;
  logic        strap_swing_s;
  logic [6:0]  pin_addr_s;
  logic        bank_rst;

  scr_sync #(
    .WIDTH   (14),
    .RST_VAL (14'h0007)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({pin_bus_address, strap_output_swing_select, strap_latch_edge_select,
                strap_mode, power_down_n, sda_in, scl_in}),
    .sync_out (pins_s)
  );

  assign scl_s         = pins_s[0];
  assign sda_s         = pins_s[1];
  assign pdn_s         = pins_s[2];
  assign strap_mode_s  = pins_s[4:3];
  assign strap_edge_s  = pins_s[5];
  assign strap_swing_s = pins_s[6];
  assign pin_addr_s    = pins_s[13:7];
  // power-down clears the bank, sleep does not
  assign bank_rst      = rst | ~pdn_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus line edges and power-up wait

  logic          scl_d_r;
  logic          sda_d_r;
  logic [CW-1:0] wait_r;
  logic [CW-1:0] wait_nxt;
  logic          ready_r;
  logic          ready_nxt;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always_comb begin
    wait_nxt  = wait_r;
    ready_nxt = ready_r;
    if (!ready_r) begin
      if (wait_r == CW'(POWERUP_CYCLES - 1)) begin
        ready_nxt = 1'b1;
      end else begin
        wait_nxt = wait_r + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (bank_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      wait_r  <= '0;
      ready_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wait_r  <= wait_nxt;
      ready_r <= ready_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  scr_pkg::scr_byte_t cfg_r;
  scr_pkg::scr_byte_t cfg_nxt;
  scr_pkg::scr_byte_t id_r;
  scr_pkg::scr_byte_t id_nxt;
  scr_pkg::scr_byte_t emph_r;
  scr_pkg::scr_byte_t emph_nxt;
  logic               wr_en;
  scr_pkg::scr_byte_t wr_addr;
  scr_pkg::scr_byte_t wr_data;

  function automatic scr_pkg::scr_byte_t rd_byte(input scr_pkg::scr_byte_t a, input scr_pkg::scr_byte_t c,
                                                 input scr_pkg::scr_byte_t i, input scr_pkg::scr_byte_t e);
    case (a)
      `SCR_ADDR_CFG_ONE: rd_byte = c;
      `SCR_ADDR_BUS_ID:  rd_byte = i;
      `SCR_ADDR_EMPH:    rd_byte = e;
      default:           rd_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    cfg_nxt  = cfg_r;
    id_nxt   = id_r;
    emph_nxt = emph_r;
    if (wr_en) begin
      case (wr_addr)
        `SCR_ADDR_CFG_ONE: cfg_nxt  = wr_data & `SCR_CFG_ONE_MASK;
        `SCR_ADDR_BUS_ID:  id_nxt   = wr_data;
        `SCR_ADDR_EMPH:    emph_nxt = wr_data & `SCR_EMPH_MASK;
        default:           cfg_nxt  = cfg_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (bank_rst) begin
      cfg_r  <= `SCR_CFG_ONE_RST;
      id_r   <= `SCR_BUS_ID_RST;
      emph_r <= `SCR_EMPH_RST;
    end else begin
      cfg_r  <= cfg_nxt;
      id_r   <= id_nxt;
      emph_r <= emph_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective configuration outputs

  logic       reg_mode;
  logic [6:0] id_field;
  logic       id_valid;
  logic [1:0] mode_nxt;
  logic [6:0] addr_nxt;
  logic [2:0] lvl_nxt;

  assign reg_mode = cfg_r[`SCR_CFG_REG_BIT];
  assign id_field = id_r[`SCR_ID_ADDR_MSB:0];
  // reserved codes in the field never reach the bus decoder
  assign id_valid = (id_field == `SCR_VALID_ADDR_0) || (id_field == `SCR_VALID_ADDR_1) ||
                    (id_field == `SCR_VALID_ADDR_2) || (id_field == `SCR_VALID_ADDR_3);

  always_comb begin
    mode_nxt = reg_mode ? cfg_r[`SCR_CFG_MODE_MSB:`SCR_CFG_MODE_LSB] : strap_mode_s;
    addr_nxt = (id_r[`SCR_ID_SRC_BIT] && id_valid) ? id_field : pin_addr_s;
    lvl_nxt  = reg_mode ? emph_r[`SCR_EMPH_LVL_MSB:`SCR_EMPH_LVL_LSB] : `SCR_EMPH_EXTERNAL;
  end

  always_ff @(posedge sys_clk) begin
    if (bank_rst) begin
      compat_mode         <= `SCR_MODE_FILT_OFF;
      ctl_filter_en       <= 1'b0;
      backcompat_gen2     <= 1'b0;
      backcompat_gen1     <= 1'b0;
      sleep_mode          <= 1'b0;
      latch_edge_select   <= 1'b0;
      output_swing_select <= 1'b0;
      emphasis_level      <= `SCR_EMPH_EXTERNAL;
      emphasis_disable    <= 1'b0;
      bus_address_field   <= `SCR_VALID_ADDR_3;
    end else begin
      compat_mode         <= mode_nxt;
      ctl_filter_en       <= (mode_nxt == `SCR_MODE_FILT_ON);
      backcompat_gen2     <= (mode_nxt == `SCR_MODE_GEN2);
      backcompat_gen1     <= (mode_nxt == `SCR_MODE_GEN1);
      sleep_mode          <= cfg_r[`SCR_CFG_SLEEP_BIT];
      latch_edge_select   <= reg_mode ? cfg_r[`SCR_CFG_EDGE_BIT] : strap_edge_s;
      output_swing_select <= reg_mode ? cfg_r[`SCR_CFG_SWING_BIT] : strap_swing_s;
      emphasis_level      <= lvl_nxt;
      emphasis_disable    <= reg_mode & emph_r[`SCR_EMPH_DIS_BIT];
      bus_address_field   <= addr_nxt;
    end
  end

  assign bus_ready = ready_r;
  assign sda_out   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // serial bus slave engine

  scr_pkg::scr_bus_state_e st_r;
  scr_pkg::scr_bus_state_e st_nxt;
  logic [3:0]              cnt_r;
  logic [3:0]              cnt_nxt;
  scr_pkg::scr_byte_t      sh_r;
  scr_pkg::scr_byte_t      sh_nxt;
  scr_pkg::scr_byte_t      tx_r;
  scr_pkg::scr_byte_t      tx_nxt;
  scr_pkg::scr_byte_t      ptr_r;
  scr_pkg::scr_byte_t      ptr_nxt;
  logic                    have_ptr_r;
  logic                    have_ptr_nxt;
  logic                    rw_r;
  logic                    rw_nxt;
  logic                    nack_r;
  logic                    nack_nxt;
  logic                    oe_n_r;
  logic                    oe_n_nxt;
  scr_pkg::scr_byte_t      rd_now;

  assign rd_now = rd_byte(ptr_r, cfg_r, id_r, emph_r);

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    tx_nxt       = tx_r;
    ptr_nxt      = ptr_r;
    have_ptr_nxt = have_ptr_r;
    rw_nxt       = rw_r;
    nack_nxt     = nack_r;
    oe_n_nxt     = oe_n_r;
    wr_en        = 1'b0;
    wr_addr      = ptr_r;
    wr_data      = sh_r;
    if (!ready_r || bus_stop) begin
      st_nxt   = scr_pkg::ST_IDLE;
      oe_n_nxt = 1'b1;
    end else if (bus_start) begin
      st_nxt   = scr_pkg::ST_ADDR;
      cnt_nxt  = 4'h0;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        scr_pkg::ST_ADDR, scr_pkg::ST_RXB: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_nxt  = 4'h0;
            oe_n_nxt = 1'b0;
            if (st_r == scr_pkg::ST_RXB) begin
              st_nxt = scr_pkg::ST_WACK;
              if (!have_ptr_r) begin
                ptr_nxt      = sh_r;
                have_ptr_nxt = 1'b1;
              end else begin
                wr_en   = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
              end
            end else if (sh_r[7:1] == bus_address_field) begin
              st_nxt       = scr_pkg::ST_AACK;
              rw_nxt       = sh_r[0];
              have_ptr_nxt = 1'b0;
            end else begin
              st_nxt   = scr_pkg::ST_IDLE;
              oe_n_nxt = 1'b1;
            end
          end
        end
        scr_pkg::ST_AACK, scr_pkg::ST_WACK: begin
          if (scl_fall) begin
            if (st_r == scr_pkg::ST_AACK && rw_r) begin
              st_nxt   = scr_pkg::ST_TXB;
              tx_nxt   = rd_now;
              ptr_nxt  = ptr_r + 8'h01;
              oe_n_nxt = rd_now[7];
            end else begin
              st_nxt   = scr_pkg::ST_RXB;
              oe_n_nxt = 1'b1;
            end
          end
        end
        scr_pkg::ST_TXB: begin
          if (scl_fall) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'h7) begin
              st_nxt   = scr_pkg::ST_RACK;
              oe_n_nxt = 1'b1;
            end else begin
              tx_nxt   = {tx_r[6:0], 1'b0};
              oe_n_nxt = tx_r[6];
            end
          end
        end
        scr_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (nack_r) begin
              st_nxt = scr_pkg::ST_IDLE;
            end else begin
              st_nxt   = scr_pkg::ST_TXB;
              tx_nxt   = rd_now;
              ptr_nxt  = ptr_r + 8'h01;
              oe_n_nxt = rd_now[7];
            end
          end
        end
        default: begin
          st_nxt   = scr_pkg::ST_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (bank_rst) begin
      st_r       <= scr_pkg::ST_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      have_ptr_r <= 1'b0;
      rw_r       <= 1'b0;
      nack_r     <= 1'b0;
      oe_n_r     <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      tx_r       <= tx_nxt;
      ptr_r      <= ptr_nxt;
      have_ptr_r <= have_ptr_nxt;
      rw_r       <= rw_nxt;
      nack_r     <= nack_nxt;
      oe_n_r     <= oe_n_nxt;
    end
  end

  assign sda_oe_n = oe_n_r;

endmodule

/* src/scr_regs_fix.sv */
// holds no logic: the bank lives in scr_regs.sv and its pin synchroniser in scr_sync.sv

/* test/scr_regs_chk.sv */
// port assertions for the serializer control bank
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_regs_chk #(
  parameter int POWERUP_CYCLES = `SCR_POWERUP_CYC
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       power_down_n,
  // serial bus
  input wire logic       scl_in,
  input wire logic       sda_oe_n,
  // effective configuration
  input wire logic [1:0] compat_mode,
  input wire logic       ctl_filter_en,
  input wire logic       backcompat_gen2,
  input wire logic       backcompat_gen1,
  input wire logic       sleep_mode,
  input wire logic [2:0] emphasis_level,
  input wire logic       emphasis_disable,
  input wire logic [6:0] bus_address_field,
  input wire logic       bus_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // saturating count of cycles since reset or power-down, so a long run cannot wrap it
  logic [31:0] since_rst_r;
  logic [31:0] since_rst_nxt;
  always_comb begin
    since_rst_nxt = (since_rst_r == 32'hFFFFFFFF) ? since_rst_r : since_rst_r + 32'h1;
  end
  always_ff @(posedge sys_clk) begin
    since_rst_r <= (rst || !power_down_n) ? 32'h0 : since_rst_nxt;
  end
  // no register write can land while the clock pin stays high
  sequence scl_high_s;
    scl_in [*8];
  endsequence
  ////////////////////////////////////////
  AST_FILTER_DECODE: assert property (ctl_filter_en == (compat_mode == 2'h1))
    else $error("filter decode wrong");
  AST_GEN2_DECODE: assert property (backcompat_gen2 == (compat_mode == 2'h2))
    else $error("gen2 decode wrong");
  AST_GEN1_DECODE: assert property (backcompat_gen1 == (compat_mode == 2'h3))
    else $error("gen1 decode wrong");
  AST_SILENT_EARLY: assert property (!bus_ready |-> sda_oe_n)
    else $error("bus answered during power-up wait");
  // the power-down pin reaches the bank two sync cycles late, hence the upper bound
  AST_READY_TIME: assert property ($rose(bus_ready) |->
    since_rst_r >= POWERUP_CYCLES - 1 && since_rst_r <= POWERUP_CYCLES + 2)
    else $error("ready at wrong time");
  AST_ADDR_VALID: assert property (since_rst_r > 32'h4 |-> bus_address_field inside
    {`SCR_VALID_ADDR_0, `SCR_VALID_ADDR_1, `SCR_VALID_ADDR_2, `SCR_VALID_ADDR_3})
    else $error("reserved bus address in use");
  AST_CFG_STABLE: assert property (scl_high_s |=> $stable(sleep_mode) &&
    $stable(emphasis_level) && $stable(emphasis_disable))
    else $error("setting moved without a bus write");
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
endmodule
bind scr_regs scr_regs_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .power_down_n(power_down_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .compat_mode(compat_mode), .ctl_filter_en(ctl_filter_en), .backcompat_gen2(backcompat_gen2),
  .backcompat_gen1(backcompat_gen1), .sleep_mode(sleep_mode), .emphasis_level(emphasis_level),
  .emphasis_disable(emphasis_disable), .bus_address_field(bus_address_field), .bus_ready(bus_ready));

/* test/scr_host_model.sv */
// bus host model: drives the clock pin and pulls the data line low
`timescale 1ns/1ps
module scr_host_model (
  // clock
  input  wire logic sys_clk,
  // serial bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_powerup(input int n);
    tick(n);
  endtask
  ////////////////////////////////////////
  // phases of four cycles keep above the two the device's pin synchroniser needs
  task automatic bit_xfer(input logic b, output logic s);
    sda_low = !b;
    tick(4);
    scl = 1'b1;
    tick(4);
    s = sda;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic start_cond();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask
  // msb first; the ninth bit is released, so ack reports the device's answer
  task automatic byte_xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], q[i]);
    end
    bit_xfer(1'b1, s);
    ack = !s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start_cond();
    byte_xfer({a, 1'b0}, q, k[0]);
    byte_xfer(p, q, k[1]);
    byte_xfer(d, q, k[2]);
    stop_cond();
    ok = &k;
  endtask
  // released ninth bit after the data ends the read with a nack
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start_cond();
    byte_xfer({a, 1'b0}, q, k[0]);
    byte_xfer(p, q, k[1]);
    start_cond();
    byte_xfer({a, 1'b1}, q, k[2]);
    byte_xfer(8'hFF, d, k[3]);
    stop_cond();
    ok = &k[2:0];
  endtask
endmodule

/* test/tb_serializer_control_registers.sv */
// self-checking bench for the serializer control bank
`timescale 1ns/1ps
`include "scr_defs.svh"
module tb_serializer_control_registers;
  localparam int PUP = 20;
  logic       sys_clk, rst, scl, sda_low, sda, sda_out, sda_oe_n, power_down_n;
  logic       strap_edge, strap_swing, ctl_filter_en, backcompat_gen2, backcompat_gen1;
  logic       sleep_mode, latch_edge_select, output_swing_select, emphasis_disable, bus_ready;
  logic [1:0] strap_mode, compat_mode;
  logic [2:0] emphasis_level;
  logic [6:0] pin_addr, bus_address_field, dev_addr;
  logic [6:0] valid_tbl [4] = '{`SCR_VALID_ADDR_0, `SCR_VALID_ADDR_1, `SCR_VALID_ADDR_2, `SCR_VALID_ADDR_3};
  int         seed, fail_count, checks, cyc;
  // pulled-up open-drain data line
  assign sda = !sda_low && (sda_oe_n || sda_out);
  initial sys_clk = 1'b0;
  always #20 sys_clk = !sys_clk;
  scr_regs #(.POWERUP_CYCLES(PUP)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .power_down_n(power_down_n), .strap_mode(strap_mode), .strap_latch_edge_select(strap_edge),
    .strap_output_swing_select(strap_swing), .pin_bus_address(pin_addr), .compat_mode(compat_mode),
    .ctl_filter_en(ctl_filter_en), .backcompat_gen2(backcompat_gen2), .backcompat_gen1(backcompat_gen1),
    .sleep_mode(sleep_mode), .latch_edge_select(latch_edge_select), .output_swing_select(output_swing_select),
    .emphasis_level(emphasis_level), .emphasis_disable(emphasis_disable),
    .bus_address_field(bus_address_field), .bus_ready(bus_ready));
  scr_host_model host_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, input logic ok_exp);
    logic ok;
    host_u.wr(a, p, d, ok);
    chk_val({7'h0, ok}, {7'h0, ok_exp}, "write ack");
  endtask
  task automatic reg_rd(input logic [7:0] p, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    host_u.rd(dev_addr, p, d, ok);
    chk_val({7'h0, ok}, 8'h01, "read ack");
    chk_val(d, exp, "read data");
  endtask
  task automatic check_cfg(input logic [1:0] m, input logic e, input logic s, input logic sl);
    chk_val({6'h0, compat_mode}, {6'h0, m}, "mode");
    chk_val({5'h0, ctl_filter_en, backcompat_gen2, backcompat_gen1},
      {5'h0, m == 2'h1, m == 2'h2, m == 2'h3}, "mode decode");
    chk_val({6'h0, latch_edge_select, output_swing_select}, {6'h0, e, s}, "edge swing");
    chk_val({7'h0, sleep_mode}, {7'h0, sl}, "sleep");
  endtask
  // reserved bits set on purpose: the device must drop them
  function automatic logic [7:0] cfg_word(input logic [1:0] m, input logic src);
    return {2'h3, 1'($random(seed)), 1'($random(seed)), m, 1'($random(seed)), src};
  endfunction
  ////////////////////////////////////////
  initial begin
    logic [7:0] w, e;
    int pidx;
    seed = 71027;
    {fail_count, checks, cyc} = '0;
    rst = 1'b1;
    power_down_n = 1'b1;
    strap_mode = 2'($random(seed));
    strap_edge = 1'($random(seed));
    strap_swing = 1'($random(seed));
    pidx = $unsigned($random(seed)) % 4;
    pin_addr = valid_tbl[pidx];
    dev_addr = pin_addr;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    host_u.tick(2);
    chk_val({7'h0, bus_ready}, 8'h00, "early ready");
    host_u.wait_powerup(PUP + 4);
    chk_val({7'h0, bus_ready}, 8'h01, "ready");
    check_cfg(strap_mode, strap_edge, strap_swing, 1'b0);
    chk_val({1'h0, bus_address_field}, {1'h0, pin_addr}, "pin address");
    reg_rd(`SCR_ADDR_CFG_ONE, 8'h00);
    reg_rd(`SCR_ADDR_BUS_ID, 8'h68);
    reg_rd(`SCR_ADDR_EMPH, 8'h00);
    reg_rd(8'h03, 8'h00);
    $display("test defaults done");
    for (int m = 0; m < 4; m++) begin
      w = cfg_word(2'(m), 1'b1);
      reg_wr(dev_addr, `SCR_ADDR_CFG_ONE, w, 1'b1);
      reg_rd(`SCR_ADDR_CFG_ONE, w & 8'h3F);
      check_cfg(w[3:2], w[4], w[5], w[1]);
    end
    for (int l = 0; l < 8; l++) begin
      e = {3'(l), 1'($random(seed)), 4'($random(seed))};
      reg_wr(dev_addr, `SCR_ADDR_EMPH, e, 1'b1);
      reg_rd(`SCR_ADDR_EMPH, e & 8'hF0);
      chk_val({4'h0, emphasis_level, emphasis_disable}, {4'h0, e[7:4]}, "emphasis");
    end
    $display("test register mode done");
    reg_wr(dev_addr, `SCR_ADDR_CFG_ONE, cfg_word(2'h3, 1'b0) | 8'h02, 1'b1);
    strap_mode = ~strap_mode;
    host_u.tick(6);
    check_cfg(strap_mode, strap_edge, strap_swing, 1'b1);
    chk_val({4'h0, emphasis_level, emphasis_disable}, 8'h00, "strap emphasis");
    reg_rd(`SCR_ADDR_EMPH, e & 8'hF0);
    reg_wr(dev_addr, `SCR_ADDR_CFG_ONE, 8'h00, 1'b1);
    check_cfg(strap_mode, strap_edge, strap_swing, 1'b0);
    $display("test strap mode done");
    w = {1'b1, valid_tbl[(pidx + 1) % 4]};
    reg_wr(dev_addr, `SCR_ADDR_BUS_ID, w, 1'b1);
    chk_val({1'h0, bus_address_field}, {1'h0, w[6:0]}, "register address");
    reg_wr(pin_addr, `SCR_ADDR_CFG_ONE, 8'h01, 1'b0);
    check_cfg(strap_mode, strap_edge, strap_swing, 1'b0);
    dev_addr = w[6:0];
    reg_rd(`SCR_ADDR_BUS_ID, w);
    reg_wr(dev_addr, `SCR_ADDR_BUS_ID, 8'hF0, 1'b1);
    chk_val({1'h0, bus_address_field}, {1'h0, pin_addr}, "reserved address");
    dev_addr = pin_addr;
    reg_rd(`SCR_ADDR_BUS_ID, 8'hF0);
    reg_wr(dev_addr, `SCR_ADDR_BUS_ID, {1'b0, w[6:0]}, 1'b1);
    chk_val({1'h0, bus_address_field}, {1'h0, pin_addr}, "source pin");
    $display("test address done");
    // unlike sleep, the power-down pin loses every register and restarts the quiet time
    power_down_n = 1'b0;
    host_u.tick(4);
    chk_val({7'h0, bus_ready}, 8'h00, "power-down ready");
    power_down_n = 1'b1;
    host_u.wait_powerup(PUP + 6);
    chk_val({7'h0, bus_ready}, 8'h01, "ready after power-down");
    reg_rd(`SCR_ADDR_EMPH, 8'h00);
    reg_rd(`SCR_ADDR_BUS_ID, 8'h68);
    $display("test power-down done");
    wrap_up();
  end
endmodule
